// ---- design/mode_timer_pkg.sv ----
// Purpose: Shared constants for the sixteen-bit mode timer
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Offsets, field positions and reset values live only here

package mode_timer_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_RELOAD  = 8'h08;
  localparam logic [7:0] OFS_CAPTURE = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;

  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PRESCALE_SELECT_LSB = 4;
  localparam int CTRL_POL_BIT  = 7;
  localparam int CTRL_OUTEN_BIT = 8;
  localparam int CTRL_WIDTH    = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // ****************************************************
  // Status / mask fields
  // ****************************************************
  localparam int ST_RELOAD  = 0;
  localparam int ST_GATEOFF = 1;
  localparam int ST_CAPTURE = 2;
  localparam int ST_WIDTH   = 3;
  localparam logic [2:0] ST_RESET = 3'h0;

  // ****************************************************
  // Counter values
  // ****************************************************
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [15:0] COUNT_WRAP    = 16'h0000;
  localparam int          PRESCALE_SELECT_WIDTH    = 7;

  // ****************************************************
  // Timer modes
  // ****************************************************
  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h0,
    MODE_CONTIN  = 3'h1,
    MODE_COUNTER = 3'h2,
    MODE_PWM     = 3'h3,
    MODE_CAPTURE = 3'h4,
    MODE_COMPARE = 3'h5,
    MODE_GATED   = 3'h6,
    MODE_CAPCMP  = 3'h7
  } timer_mode_t;

endpackage : mode_timer_pkg

// ---- design/timer_prescaler.sv ----
// Purpose: Power-of-two prescaler for the mode timer
// Assumes: Single clock, synchronous active-low reset
// Notes:   Tick is combinational; the parent registers all outputs

`timescale 1ns/1ns

module timer_prescaler
  import mode_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clear,
  input  wire logic       advance,
  input  wire logic [2:0] prescaleSelect,
  // Divided tick
  output logic            tick
);

  logic [PRESCALE_SELECT_WIDTH-1:0] divCnt_q;
  logic [PRESCALE_SELECT_WIDTH-1:0] divMask;

  // Mask of low bits that must be all ones: 2**sel - 1
  assign divMask = PRESCALE_SELECT_WIDTH'((8'h01 << prescaleSelect) - 8'h01);

  // Tick on the last phase of each divide period
  assign tick = advance && ((divCnt_q & divMask) == divMask);

  // Phase counter; cleared while stopped so restarts are clean
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clear) begin
      divCnt_q <= '0;
    end else if (advance) begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

endmodule : timer_prescaler

// ---- design/sixteen_bit_mode_timer.sv ----
// Purpose: Sixteen-bit eight-mode timer with Wishbone register access
// Assumes: ref_clk 10 MHz system clock; timerIn is an asynchronous pin
// Notes:   Reload events, gate release and captures raise interrupts
//
// What this block does
// - Gated mode counts only while input sits at its active level.
// - Gated mode interrupts on input release and on every reload.
// - Gated count reaching reload restarts at 0001 and continues.
// - Gated mode counts prescaled system clock, never the pin.
// - Gated reload toggles timer output when output is enabled.
// - Capture latches count on rising edge (pol 0) or falling (pol 1).
// - Compare: disabled output equals polarity; enabled toggles at reload.
// - Gated pol 0 gates on high input, pol 1 on low input.
// - Capture/compare starts on first selected edge, captures on later ones.
// - Prescaler divides by two to the power of the 3-bit field, except in counter mode (no division).
// - Prescaler is cleared whenever the timer is disabled.
// - Mode field selects one of eight modes, 000 to 111.
// - Compare delay is (compare minus start) times divisor clocks.
// - Compare counter wraps from FFFF to 0000 and keeps counting.
// - Compare mode is clocked by prescaled system clock only.

`timescale 1ns/1ns

module sixteen_bit_mode_timer
  import mode_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Timer pins
  input  wire logic        timerIn,
  output logic             timerOut,
  // Interrupt
  output logic             irq
);

  // ****************************************************
  // Functions
  // ****************************************************

  // Apply the two low byte lanes to a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    mergeLanes = {sel[1] ? wdat[15:8] : old[15:8],
                  sel[0] ? wdat[7:0]  : old[7:0]};
  endfunction : mergeLanes

  // Count has reached the reload (compare) value
  function automatic logic atReload(input logic [15:0] cnt,
                                    input logic [15:0] rld);
    atReload = (cnt == rld);
  endfunction : atReload

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [15:0]           count_q;
  logic [15:0]           reload_q;
  logic [15:0]           capture_q;
  logic [ST_WIDTH-1:0]   status_q;
  logic [ST_WIDTH-1:0]   mask_q;
  logic [31:0]           datO_q;
  logic                  ack_q;
  logic                  irq_q;
  logic                  timerOut_q;
  logic                  started_q;
  logic                  inMeta_q;
  logic                  inSync_q;
  logic                  inPrev_q;

  logic                  enable;
  logic                  polarity;
  logic                  outEnable;
  logic [2:0]            prescaleSelect;
  timer_mode_t           timerMode;
  logic                  busAccess;
  logic                  busWrite;
  logic                  wrCtrl;
  logic                  wrCount;
  logic                  gateActive;
  logic                  gateOff;
  logic                  selEdge;
  logic                  advance;
  logic                  tick;
  logic                  reloadHit;
  logic                  captureHit;
  logic [ST_WIDTH-1:0]   events;

  assign enable         = ctrl_q[CTRL_EN_BIT];
  assign polarity       = ctrl_q[CTRL_POL_BIT];
  assign outEnable      = ctrl_q[CTRL_OUTEN_BIT];
  assign prescaleSelect = ctrl_q[CTRL_PRESCALE_SELECT_LSB +: 3];
  assign timerMode      = timer_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);

  // ****************************************************
  // Wishbone slave
  // ****************************************************

  // Write lands at the edge where the master sees ack
  assign busAccess = cyc_i && stb_i && ack_q;
  assign busWrite  = busAccess && we_i;
  assign wrCtrl    = busWrite && (adr_i == OFS_CTRL);
  assign wrCount   = busWrite && (adr_i == OFS_COUNT);

  // One wait state: ack one cycle after the request, dropped after
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  // Read data registered; unmapped offsets read as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      datO_q <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_q) begin
      unique case (adr_i)
        OFS_CTRL:    datO_q <= 32'(ctrl_q);
        OFS_COUNT:   datO_q <= 32'(count_q);
        OFS_RELOAD:  datO_q <= 32'(reload_q);
        OFS_CAPTURE: datO_q <= 32'(capture_q);
        OFS_STATUS:  datO_q <= 32'(status_q);
        OFS_MASK:    datO_q <= 32'(mask_q);
        default:     datO_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; one-shot clears enable after its reload
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= {sel_i[1] ? dat_i[8] : ctrl_q[8],
                 sel_i[0] ? dat_i[7:0] : ctrl_q[7:0]};
    end else if (reloadHit && timerMode == MODE_ONESHOT) begin
      ctrl_q[CTRL_EN_BIT] <= 1'b0;
    end
  end

  // Reload and mask registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reload_q <= RELOAD_RESET;
      mask_q   <= ST_RESET;
    end else begin
      if (busWrite && adr_i == OFS_RELOAD) begin
        reload_q <= mergeLanes(reload_q, dat_i, sel_i);
      end
      if (busWrite && adr_i == OFS_MASK && sel_i[0]) begin
        mask_q <= dat_i[ST_WIDTH-1:0];
      end
    end
  end

  // ****************************************************
  // Input synchroniser and edge detect
  // ****************************************************

  // Two flops before any use; third flop only for edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inMeta_q <= 1'b0;
      inSync_q <= 1'b0;
      inPrev_q <= 1'b0;
    end else begin
      inMeta_q <= timerIn;
      inSync_q <= inMeta_q;
      inPrev_q <= inSync_q;
    end
  end

  // Polarity 0 means high is active and rising is the chosen edge
  assign gateActive = inSync_q ^ polarity;
  assign gateOff    = (inPrev_q ^ polarity) && !gateActive;
  assign selEdge    = polarity ? (inPrev_q && !inSync_q)
                               : (!inPrev_q && inSync_q);

  // ****************************************************
  // Prescaler and count sequencing
  // ****************************************************

  // Which modes let the prescaled system clock advance the count
  always_comb begin
    advance = 1'b0;
    unique case (timerMode)
      MODE_GATED:   advance = enable && gateActive;
      MODE_CAPCMP:  advance = enable && started_q;
      MODE_COUNTER: advance = enable && selEdge;
      MODE_ONESHOT, MODE_CONTIN, MODE_PWM,
      MODE_CAPTURE, MODE_COMPARE:
                    advance = enable;
    endcase
  end

  // Counter mode ticks on each selected pin edge, so no division there
  timer_prescaler u_prescaler (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .clear          (!enable),
    .advance        (advance),
    .prescaleSelect ((timerMode == MODE_COUNTER) ? 3'h0 : prescaleSelect),
    .tick           (tick)
  );

  // Compare matches on the tick that brings the count to the compare
  // value, so the delay is (compare - start) divided ticks; others
  // restart on the tick after the count sits at reload
  assign reloadHit  = tick && ((timerMode == MODE_COMPARE)
                      ? atReload(count_q + 16'h0001, reload_q)
                      : atReload(count_q, reload_q));
  assign captureHit = enable && selEdge &&
                      ((timerMode == MODE_CAPTURE) ||
                       (timerMode == MODE_CAPCMP && started_q));

  // Counter; a software write wins over counting
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_q <= COUNT_RESET;
    end else if (wrCount) begin
      count_q <= mergeLanes(count_q, dat_i, sel_i);
    end else if (tick) begin
      if (timerMode == MODE_COMPARE) begin
        count_q <= (count_q == COUNT_MAX) ? COUNT_WRAP
                                          : count_q + 16'h0001;
      end else if (atReload(count_q, reload_q)) begin
        count_q <= COUNT_RESTART;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Capture/compare waits for the first chosen edge before running
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !enable) begin
      started_q <= 1'b0;
    end else if (timerMode == MODE_CAPCMP && selEdge) begin
      started_q <= 1'b1;
    end
  end

  // Capture register holds the count seen at the selected edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      capture_q <= COUNT_RESET;
    end else if (captureHit) begin
      capture_q <= count_q;
    end
  end

  // ****************************************************
  // Timer output
  // ****************************************************

  // Compare mode parks at the polarity level while stopped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timerOut_q <= 1'b0;
    end else if (timerMode == MODE_COMPARE && !enable) begin
      timerOut_q <= polarity;
    end else if (reloadHit &&
                 (timerMode == MODE_COMPARE || outEnable)) begin
      timerOut_q <= !timerOut_q;
    end
  end

  // ****************************************************
  // Interrupt status
  // ****************************************************
  assign events[ST_RELOAD]  = reloadHit;
  assign events[ST_GATEOFF] = enable && timerMode == MODE_GATED
                              && gateOff;
  assign events[ST_CAPTURE] = captureHit;

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= ST_RESET;
    end else if (busWrite && adr_i == OFS_STATUS && sel_i[0]) begin
      status_q <= (status_q & ~dat_i[ST_WIDTH-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign dat_o    = datO_q;
  assign ack_o    = ack_q;
  assign irq      = irq_q;
  assign timerOut = timerOut_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_gated_restart;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_GATED && reloadHit && !wrCount)
      |=> (count_q == COUNT_RESTART);
  endproperty
  a_gated_restart: assert property (p_gated_restart)
    else $error("gated count did not restart at one");

  property p_gated_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_GATED && !gateActive && !wrCount)
      |=> (count_q == $past(count_q));
  endproperty
  a_gated_hold: assert property (p_gated_hold)
    else $error("gated count moved while input inactive");

  property p_gated_release_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_GATED && enable && gateOff)
      |=> status_q[ST_GATEOFF];
  endproperty
  a_gated_release_irq: assert property (p_gated_release_irq)
    else $error("gate release did not set status");

  property p_gated_toggle;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_GATED && reloadHit && outEnable)
      |=> (timerOut != $past(timerOut));
  endproperty
  a_gated_toggle: assert property (p_gated_toggle)
    else $error("timer output did not toggle on gated reload");

  property p_compare_idle_level;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_COMPARE && !enable && !wrCtrl)
      |=> (timerOut == $past(polarity));
  endproperty
  a_compare_idle_level: assert property (p_compare_idle_level)
    else $error("compare output not at polarity while disabled");

  property p_capture_value;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_CAPTURE && enable && selEdge)
      |=> (capture_q == $past(count_q));
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("capture register missed the count");

  property p_restart_phase;
    @(posedge ref_clk) disable iff (!rst_n)
      ($rose(enable) && prescaleSelect != 3'h0
       && timerMode != MODE_COUNTER) |-> !tick;
  endproperty
  a_restart_phase: assert property (p_restart_phase)
    else $error("prescaler not cleared while disabled");

  property p_compare_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_COMPARE && tick && count_q == COUNT_MAX
       && !wrCount) |=> (count_q == COUNT_WRAP);
  endproperty
  a_compare_wrap: assert property (p_compare_wrap)
    else $error("compare counter did not wrap to zero");

  property p_div_by_eight;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_COMPARE && tick && prescaleSelect == 3'h3
       && !wrCtrl) |=> !tick [*7];
  endproperty
  a_div_by_eight: assert property (p_div_by_eight)
    else $error("divide by eight ticked early");

  property p_capcmp_wait;
    @(posedge ref_clk) disable iff (!rst_n)
      (timerMode == MODE_CAPCMP && !started_q && !wrCount)
      |=> (count_q == $past(count_q));
  endproperty
  a_capcmp_wait: assert property (p_capcmp_wait)
    else $error("capture/compare counted before first edge");

endmodule : sixteen_bit_mode_timer

// ---- dv/timer_pin_model.sv ----
// Purpose: Outside source for the timer input pin, watcher of output
// Assumes: Pin changes land after a programmable lag of clock cycles
// Notes:   Lag 0 answers at once, larger lags make a slow source

`timescale 1ns/1ns

module timer_pin_model (
  // Clock
  input  wire logic       ref_clk,
  // Requested level and lag
  input  wire logic       level,
  input  wire logic [2:0] lag,
  // Timer pins
  output logic            timerIn,
  input  wire logic       timerOut,
  // Edges seen on the output pin
  output int              outToggles
);
  logic [2:0] waitQ;
  logic       prevOutQ;

  initial begin
    timerIn    = 1'b0;
    waitQ      = 3'h0;
    prevOutQ   = 1'b0;
    outToggles = 0;
  end

  // Follow the request late; uneven lags stress the synchroniser
  always @(posedge ref_clk) begin
    if (level === timerIn) begin
      waitQ <= 3'h0;
    end else if (waitQ >= lag) begin
      timerIn <= level;
      waitQ   <= 3'h0;
    end else begin
      waitQ <= waitQ + 3'h1;
    end
  end

  // Count output edges; only differences are used by the bench
  always @(posedge ref_clk) begin
    prevOutQ <= timerOut;
    if (timerOut !== prevOutQ) begin
      outToggles <= outToggles + 1;
    end
  end
endmodule : timer_pin_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the sixteen-bit mode timer
// Assumes: Wishbone answers after one wait; pin model drives timerIn
// Notes:   Fixed seed; expectations come from bench arithmetic only

`timescale 1ns/1ns

`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin \
  failCount++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb;
  import mode_timer_pkg::*;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, q1;
  logic ack, timerIn, timerOut, irq, level = 1'b0;
  logic [2:0] lag = 3'h0;
  int outToggles, t0, failCount = 0, nChecks = 0, seed = 71969;

  // ****************************************************
  // Clock, design, pin source
  // ****************************************************
  always #50 ref_clk = ~ref_clk;

  sixteen_bit_mode_timer u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .timerIn(timerIn),
    .timerOut(timerOut), .irq(irq));

  timer_pin_model u_pin (
    .ref_clk(ref_clk), .level(level), .lag(lag), .timerIn(timerIn),
    .timerOut(timerOut), .outToggles(outToggles));

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tallyAndFinish

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin
      failCount++;
      $display("BAD %0t no bus answer", $time);
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // Move the pin with a random lag, then allow for synchronising
  task automatic setPin(input logic v);
    int n;
    n = 0;
    lag <= 3'($random(seed));
    level <= v;
    while (timerIn !== v && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (5) @(posedge ref_clk);
  endtask : setPin

  function automatic logic [31:0] cfg(logic en, logic [2:0] m,
      logic [2:0] p, logic pol, logic oe);
    return 32'({oe, pol, p, m, en});
  endfunction : cfg

  // Compare run: match expected after (compare - start) * 2**p clocks
  task automatic cmpRun(input logic [2:0] p, input logic [15:0] s,
                        input logic [15:0] c);
    int d;
    d = int'(16'(c - s)) << p;
    wr(OFS_CTRL, cfg(1'b0, MODE_COMPARE, p, 1'b0, 1'b0));
    wr(OFS_COUNT, 32'(s));
    wr(OFS_RELOAD, 32'(c));
    wr(OFS_STATUS, 32'h7);
    t0 = outToggles;
    wr(OFS_CTRL, cfg(1'b1, MODE_COMPARE, p, 1'b0, 1'b0));
    level <= 1'($random(seed));           // Pin must not clock it
    repeat (d - 4) @(posedge ref_clk);
    rd(OFS_STATUS);
    `CHK(q[ST_RELOAD], 1'b0)
    repeat (8) @(posedge ref_clk);
    rd(OFS_STATUS);
    `CHK(q[ST_RELOAD], 1'b1)
    `CHK(outToggles - t0, 1)
  endtask : cmpRun

  // Gated run; inactive level equals the polarity bit
  task automatic gatedRun(input logic pol);
    wr(OFS_CTRL, cfg(1'b0, MODE_GATED, 3'h0, pol, 1'b1));
    wr(OFS_COUNT, 32'h0);
    wr(OFS_RELOAD, 32'h5);
    setPin(pol);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_MASK, 32'h7);
    wr(OFS_CTRL, cfg(1'b1, MODE_GATED, 3'h0, pol, 1'b1));
    repeat (10) @(posedge ref_clk);
    rd(OFS_COUNT);
    `CHK(q, 32'h0)
    t0 = outToggles;
    setPin(~pol);
    repeat (20) @(posedge ref_clk);
    setPin(pol);
    rd(OFS_COUNT);
    q1 = q;
    `CHK(q1 >= 32'h1 && q1 <= 32'h5, 1'b1)
    repeat (10) @(posedge ref_clk);
    rd(OFS_COUNT);
    `CHK(q, q1)
    rd(OFS_STATUS);
    `CHK(q[1:0], 2'b11)
    `CHK(irq, 1'b1)
    `CHK(outToggles - t0 >= 3, 1'b1)
    wr(OFS_MASK, 32'h0);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(OFS_MASK, 32'h7);
    wr(OFS_STATUS, 32'h7);
    repeat (3) @(posedge ref_clk);
    `CHK(irq, 1'b0)
  endtask : gatedRun

  // Capture modes; idle level equals the polarity bit
  task automatic capRun(input timer_mode_t m, input logic pol);
    wr(OFS_CTRL, cfg(1'b0, m, 3'h0, pol, 1'b0));
    wr(OFS_COUNT, 32'h0);
    setPin(pol);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, cfg(1'b1, m, 3'h0, pol, 1'b0));
    repeat (10) @(posedge ref_clk);
    rd(OFS_COUNT);
    if (m == MODE_CAPCMP) `CHK(q, 32'h0)
    setPin(~pol);
    rd(OFS_STATUS);
    `CHK(q[ST_CAPTURE], m == MODE_CAPTURE)
    wr(OFS_STATUS, 32'h7);
    setPin(pol);
    rd(OFS_STATUS);
    `CHK(q[ST_CAPTURE], 1'b0)
    setPin(~pol);
    rd(OFS_STATUS);
    `CHK(q[ST_CAPTURE], 1'b1)
    rd(OFS_CAPTURE);
    `CHK(q != 32'h0, 1'b1)
  endtask : capRun

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    logic [7:0]  ofs [7];
    logic [31:0] rv [7];
    ofs = '{OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_CAPTURE, OFS_STATUS,
            OFS_MASK, 8'h18};
    rv = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i]);
      `CHK(q, rv[i])
    end
    for (int m = 0; m < 8; m++) begin
      wr(OFS_CTRL, cfg(1'b0, 3'(m), 3'h0, 1'b0, 1'b0));
      rd(OFS_CTRL);
      `CHK(q[3:1], 3'(m))
    end
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, cfg(1'b0, MODE_COMPARE, 3'h0, 1'(p), 1'b0));
      repeat (2) @(posedge ref_clk);
      `CHK(timerOut, 1'(p))
    end
    for (int p = 0; p < 8; p++) begin
      cmpRun(3'(p), 16'h0, 16'(8 + ($random(seed) & 7)));
    end
    cmpRun(3'h0, 16'hfff0, 16'h0004);
    gatedRun(1'b0);
    gatedRun(1'b1);
    capRun(MODE_CAPTURE, 1'b0);
    capRun(MODE_CAPTURE, 1'b1);
    capRun(MODE_CAPCMP, 1'b0);
    capRun(MODE_CAPCMP, 1'b1);
    tallyAndFinish();
  end

  // Whole run is a few thousand cycles; this is ample headroom
  initial begin
    #(100 * 40000);
    failCount++;
    tallyAndFinish();
  end
endmodule : tb
